// [adcc_ctrl.sv]
// Calibration coefficient, input routing and reference supervision control behind the serial port.
`timescale 1ns/1ps
module adcc_ctrl #(
  parameter logic [23:0] FULL_SCALE_FACTORY = 24'h500000
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic ref_below_low_i,
  input wire logic ref_above_high_i,
  input wire logic conv_done_i,
  input wire logic [23:0] conv_data_i,
  input wire logic cal_done_i,
  input wire logic [23:0] cal_coef_i,
  output logic dout_o,
  output logic [2:0] active_mode_o,
  output logic [1:0] clk_src_o,
  output logic cal_start_o,
  output logic [3:0] mux_pos_o,
  output logic [3:0] mux_neg_o,
  output logic mux_neg_common_o,
  output logic buf_en_o,
  output logic [2:0] gain_o,
  output logic reference_source_choice_o,
  output logic ref_two_pins_ref_o,
  output logic no_reference_flag_o,
  output logic [23:0] offset_coef_o,
  output logic [23:0] full_scale_coef_o
);

  // ==========================================================================
  // Serial register port.
  // The port pins are sampled by clk_i, so the serial clock must run well below it.
  adcc_pkg::adcc_ser_t ser_q;
  logic sclk_q;
  logic [23:0] sh_in_q;
  logic [23:0] sh_out_q;
  logic [4:0] cnt_q;
  logic [4:0] len_q;
  logic [2:0] rsel_q;
  logic wr_q;
  logic [2:0] wr_reg_q;
  logic [23:0] wr_data_q;
  logic data_read_q;
  logic [23:0] mode_q;
  logic [23:0] cfg_q;
  logic [23:0] data_q;
  logic [23:0] offset_q;
  logic [23:0] full_q;
  logic ready_n_q;
  logic err_q;
  logic no_reference_flag_q;
  logic cal_busy_q;
  logic cal_bad_q;
  logic [2:0] cal_kind_q;

  wire logic sclk_rise = sclk_i && !sclk_q && !cs_n_i;
  wire logic sclk_fall = !sclk_i && sclk_q && !cs_n_i;
  wire logic [23:0] sh_next = {sh_in_q[22:0], din_i};
  wire logic [2:0] comm_rs = sh_next[adcc_pkg::ADCC_COMM_RS_LSB +: 3];
  wire logic [4:0] cnt_next = cnt_q + 5'h01;
  wire logic [7:0] status_byte = {ready_n_q, err_q, no_reference_flag_q, 5'h00};

  // Read value of a register, left-aligned so the first bit out is its top bit.
  logic [23:0] rd_word;
  logic [4:0] rd_len;
  always_comb begin
    rd_len = adcc_pkg::ADCC_LEN_WORD;
    unique case (comm_rs)
      adcc_pkg::ADCC_REG_STATUS: begin
        rd_word = {status_byte, 16'h0000};
        rd_len = adcc_pkg::ADCC_LEN_BYTE;
      end
      adcc_pkg::ADCC_REG_MODE: rd_word = mode_q;
      adcc_pkg::ADCC_REG_CONFIG: rd_word = cfg_q;
      adcc_pkg::ADCC_REG_DATA: rd_word = data_q;
      adcc_pkg::ADCC_REG_OFFSET: rd_word = offset_q;
      adcc_pkg::ADCC_REG_FULL_SCALE: rd_word = full_q;
      default: rd_word = 24'h000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk_i;
    end
  end

  // Every frame opens with the communications byte; deselecting aborts the frame.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ser_q <= adcc_pkg::ADCC_SER_COMM;
      sh_in_q <= 24'h000000;
      sh_out_q <= 24'h000000;
      cnt_q <= 5'h00;
      len_q <= adcc_pkg::ADCC_LEN_WORD;
      rsel_q <= 3'h0;
      wr_q <= 1'b0;
      wr_reg_q <= 3'h0;
      wr_data_q <= 24'h000000;
      data_read_q <= 1'b0;
      dout_o <= 1'b1;
    end else begin
      wr_q <= 1'b0;
      data_read_q <= 1'b0;
      if (cs_n_i) begin
        ser_q <= adcc_pkg::ADCC_SER_COMM;
        cnt_q <= 5'h00;
        dout_o <= ready_n_q;
      end else begin
        unique case (ser_q)
          adcc_pkg::ADCC_SER_COMM: begin
            if (ser_q == adcc_pkg::ADCC_SER_COMM && cnt_q == 5'h00) begin
              dout_o <= ready_n_q;
            end
            if (sclk_rise) begin
              sh_in_q <= sh_next;
              cnt_q <= cnt_next;
              if (cnt_next == adcc_pkg::ADCC_LEN_BYTE) begin
                cnt_q <= 5'h00;
                rsel_q <= comm_rs;
                len_q <= rd_len;
                if (sh_next[adcc_pkg::ADCC_COMM_RD_BIT]) begin
                  ser_q <= adcc_pkg::ADCC_SER_READ;
                  // The top bit shows now and again at the first falling edge, so it stands at the first data rise.
                  sh_out_q <= rd_word;
                  dout_o <= rd_word[23];
                end else begin
                  ser_q <= adcc_pkg::ADCC_SER_WRITE;
                end
              end
            end
          end
          adcc_pkg::ADCC_SER_WRITE: begin
            if (sclk_rise) begin
              sh_in_q <= sh_next;
              cnt_q <= cnt_next;
              if (cnt_next == len_q) begin
                cnt_q <= 5'h00;
                ser_q <= adcc_pkg::ADCC_SER_COMM;
                wr_q <= 1'b1;
                wr_reg_q <= rsel_q;
                wr_data_q <= sh_next;
              end
            end
          end
          adcc_pkg::ADCC_SER_READ: begin
            if (sclk_fall) begin
              dout_o <= sh_out_q[23];
              sh_out_q <= {sh_out_q[22:0], 1'b0};
            end
            if (sclk_rise) begin
              cnt_q <= cnt_next;
              if (cnt_next == len_q) begin
                cnt_q <= 5'h00;
                ser_q <= adcc_pkg::ADCC_SER_COMM;
                data_read_q <= (rsel_q == adcc_pkg::ADCC_REG_DATA);
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Mode, configuration and calibration sequencing.
  wire logic wr_mode = wr_q && wr_reg_q == adcc_pkg::ADCC_REG_MODE;
  wire logic [2:0] wr_md = wr_data_q[adcc_pkg::ADCC_MODE_MD_LSB +: 3];
  wire logic [2:0] wr_gain = wr_data_q[adcc_pkg::ADCC_CFG_GAIN_LSB +: 3];
  wire logic wr_gain_rsvd = wr_gain == adcc_pkg::ADCC_GAIN_RSVD_A || wr_gain == adcc_pkg::ADCC_GAIN_RSVD_B;
  wire logic cal_zero = cal_kind_q == adcc_pkg::ADCC_MD_INT_ZERO || cal_kind_q == adcc_pkg::ADCC_MD_SYS_ZERO;
  wire logic cal_fire = cal_busy_q && cal_done_i;
  wire logic cal_blocked = cal_bad_q || no_reference_flag_q;
  wire logic [2:0] md = mode_q[adcc_pkg::ADCC_MODE_MD_LSB +: 3];
  wire logic converting = cal_busy_q || md == adcc_pkg::ADCC_MD_CONTINUOUS || md == adcc_pkg::ADCC_MD_SINGLE;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_q <= adcc_pkg::ADCC_MODE_RST;
      cal_busy_q <= 1'b0;
      cal_kind_q <= adcc_pkg::ADCC_MD_IDLE;
      cal_start_o <= 1'b0;
    end else begin
      cal_start_o <= 1'b0;
      if (wr_mode) begin
        mode_q <= wr_data_q;
        cal_busy_q <= wr_md[2];
        cal_kind_q <= wr_md;
        cal_start_o <= wr_md[2];
      end else if (cal_fire) begin
        // A calibration leaves the converter idle; a single conversion leaves it in power-down instead.
        mode_q[adcc_pkg::ADCC_MODE_MD_LSB +: 3] <= adcc_pkg::ADCC_MD_IDLE;
        cal_busy_q <= 1'b0;
      end else if (conv_done_i && md == adcc_pkg::ADCC_MD_SINGLE) begin
        mode_q[adcc_pkg::ADCC_MODE_MD_LSB +: 3] <= adcc_pkg::ADCC_MD_POWER_DOWN;
      end
    end
  end

  // A reserved gain code is refused and the previous gain is kept.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cfg_q <= adcc_pkg::ADCC_CFG_RST;
    end else if (wr_q && wr_reg_q == adcc_pkg::ADCC_REG_CONFIG) begin
      cfg_q <= wr_data_q;
      if (wr_gain_rsvd) begin
        cfg_q[adcc_pkg::ADCC_CFG_GAIN_LSB +: 3] <= cfg_q[adcc_pkg::ADCC_CFG_GAIN_LSB +: 3];
      end
    end
  end

  // ==========================================================================
  // Calibration coefficients.
  // A direct write landing in the same cycle as a calibration result wins; the host
  // is expected not to write while a calibration runs.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      offset_q <= adcc_pkg::ADCC_OFFSET_RST;
    end else if (wr_q && wr_reg_q == adcc_pkg::ADCC_REG_OFFSET) begin
      offset_q <= wr_data_q;
    end else if (cal_fire && cal_zero && !cal_blocked) begin
      offset_q <= cal_coef_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      full_q <= FULL_SCALE_FACTORY;
    end else if (wr_q && wr_reg_q == adcc_pkg::ADCC_REG_FULL_SCALE) begin
      full_q <= wr_data_q;
    end else if (cal_fire && !cal_zero && !cal_blocked) begin
      full_q <= cal_coef_i;
    end
  end

  // Any loss of reference seen during a calibration spoils it, even if it recovers.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cal_bad_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (wr_mode && wr_md[2]) begin
        cal_bad_q <= 1'b0;
        err_q <= 1'b0;
      end else if (cal_busy_q && no_reference_flag_q) begin
        cal_bad_q <= 1'b1;
      end
      if (cal_fire && cal_blocked) begin
        err_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Reference supervision.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      no_reference_flag_q <= 1'b0;
    end else if (!cfg_q[adcc_pkg::ADCC_CFG_REFERENCE_DETECT_ENABLE_BIT]) begin
      no_reference_flag_q <= 1'b0;
    end else if (ref_below_low_i) begin
      no_reference_flag_q <= 1'b1;
    end else if (ref_above_high_i) begin
      no_reference_flag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Conversion results and data ready.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      data_q <= 24'h000000;
      ready_n_q <= 1'b1;
    end else if (conv_done_i && !cal_busy_q) begin
      data_q <= no_reference_flag_q ? adcc_pkg::ADCC_ALL_ONES : conv_data_i;
      ready_n_q <= 1'b0;
    end else if (data_read_q) begin
      ready_n_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Front-end controls.
  // Routing is retimed to conversion boundaries so a running conversion never
  // sees its inputs move under it.
  wire logic route_load = !converting || conv_done_i || cal_fire;
  wire logic [7:0] ch_field = cfg_q[adcc_pkg::ADCC_CFG_CH_LSB +: 8];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mux_pos_o <= 4'h0;
      mux_neg_o <= 4'h1;
      mux_neg_common_o <= 1'b0;
      buf_en_o <= 1'b1;
      gain_o <= 3'h0;
    end else if (route_load) begin
      mux_pos_o <= ch_field[7:4];
      mux_neg_o <= ch_field[3:0];
      mux_neg_common_o <= cfg_q[adcc_pkg::ADCC_CFG_PSEUDO_BIT];
      buf_en_o <= cfg_q[adcc_pkg::ADCC_CFG_BUF_BIT];
      gain_o <= cfg_q[adcc_pkg::ADCC_CFG_GAIN_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reference_source_choice_o <= 1'b0;
      ref_two_pins_ref_o <= 1'b0;
      active_mode_o <= adcc_pkg::ADCC_MD_IDLE;
      clk_src_o <= 2'h0;
      no_reference_flag_o <= 1'b0;
      offset_coef_o <= adcc_pkg::ADCC_OFFSET_RST;
      full_scale_coef_o <= FULL_SCALE_FACTORY;
    end else begin
      reference_source_choice_o <= cfg_q[adcc_pkg::ADCC_CFG_REFERENCE_SOURCE_CHOICE_BIT];
      ref_two_pins_ref_o <= cfg_q[adcc_pkg::ADCC_CFG_REFERENCE_SOURCE_CHOICE_BIT];
      active_mode_o <= md;
      clk_src_o <= mode_q[adcc_pkg::ADCC_MODE_CLK_LSB +: 2];
      no_reference_flag_o <= no_reference_flag_q;
      offset_coef_o <= offset_q;
      full_scale_coef_o <= full_q;
    end
  end

  // ==========================================================================
  // Checks.
  chk_no_reference_flag_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !cfg_q[adcc_pkg::ADCC_CFG_REFERENCE_DETECT_ENABLE_BIT] |=> !no_reference_flag_q)
    else $error("no-reference flag set while detection disabled");

  chk_no_reference_flag_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cfg_q[adcc_pkg::ADCC_CFG_REFERENCE_DETECT_ENABLE_BIT] && ref_below_low_i |=> no_reference_flag_q ##1 no_reference_flag_o)
    else $error("low reference not flagged");

  chk_no_reference_flag_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !ref_below_low_i && ref_above_high_i |=> !no_reference_flag_q)
    else $error("valid reference did not clear flag");

  chk_result_ones: assert property (@(posedge clk_i) disable iff (!rstn_i)
    conv_done_i && !cal_busy_q && no_reference_flag_q |=> data_q == adcc_pkg::ADCC_ALL_ONES && !ready_n_q)
    else $error("result not forced to all ones");

  chk_cal_blocked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cal_fire && cal_blocked && !wr_q |=> err_q && $stable(offset_q) && $stable(full_q))
    else $error("blocked calibration updated a coefficient");

  chk_zero_cal_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cal_fire && cal_zero && !cal_blocked && !wr_q |=> offset_q == $past(cal_coef_i) ##1 offset_coef_o == $past(offset_q))
    else $error("zero-scale calibration did not load offset");

  chk_full_cal_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cal_fire && !cal_zero && !cal_blocked && !wr_q |=> full_q == $past(cal_coef_i) && !cal_busy_q)
    else $error("full-scale calibration did not load coefficient");

  chk_route_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    converting && !conv_done_i && !cal_fire |=> $stable(mux_pos_o) && $stable(mux_neg_o) && $stable(gain_o))
    else $error("routing changed during a conversion");

  chk_gain_legal: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gain_o != adcc_pkg::ADCC_GAIN_RSVD_A && gain_o != adcc_pkg::ADCC_GAIN_RSVD_B)
    else $error("reserved gain code applied");

  chk_frame_comm: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cs_n_i |=> ser_q == adcc_pkg::ADCC_SER_COMM && cnt_q == 5'h00)
    else $error("deselect did not return to communications byte");

endmodule // adcc_ctrl

// [adcc_pkg.sv]
// Shared constants for the converter calibration and reference control block.
package adcc_pkg;

  // ==========================================================================
  // Register select codes carried by the communications byte.
  localparam logic [2:0] ADCC_REG_STATUS = 3'h0;
  localparam logic [2:0] ADCC_REG_MODE = 3'h1;
  localparam logic [2:0] ADCC_REG_CONFIG = 3'h2;
  localparam logic [2:0] ADCC_REG_DATA = 3'h3;
  localparam logic [2:0] ADCC_REG_OFFSET = 3'h6;
  localparam logic [2:0] ADCC_REG_FULL_SCALE = 3'h7;

  // ==========================================================================
  // Communications byte fields.
  localparam int ADCC_COMM_RD_BIT = 6;
  localparam int ADCC_COMM_RS_LSB = 3;

  // ==========================================================================
  // Frame lengths in serial bits.
  localparam logic [4:0] ADCC_LEN_BYTE = 5'h08;
  localparam logic [4:0] ADCC_LEN_WORD = 5'h18;

  // ==========================================================================
  // Mode register fields and operating modes.
  localparam int ADCC_MODE_MD_LSB = 21;
  localparam int ADCC_MODE_CLK_LSB = 18;
  localparam logic [2:0] ADCC_MD_CONTINUOUS = 3'h0;
  localparam logic [2:0] ADCC_MD_SINGLE = 3'h1;
  localparam logic [2:0] ADCC_MD_IDLE = 3'h2;
  localparam logic [2:0] ADCC_MD_POWER_DOWN = 3'h3;
  localparam logic [2:0] ADCC_MD_INT_ZERO = 3'h4;
  localparam logic [2:0] ADCC_MD_INT_FULL = 3'h5;
  localparam logic [2:0] ADCC_MD_SYS_ZERO = 3'h6;
  localparam logic [2:0] ADCC_MD_SYS_FULL = 3'h7;

  // ==========================================================================
  // Configuration register fields.
  localparam int ADCC_CFG_REFERENCE_SOURCE_CHOICE_BIT = 20;
  localparam int ADCC_CFG_PSEUDO_BIT = 18;
  localparam int ADCC_CFG_CH_LSB = 8;
  localparam int ADCC_CFG_REFERENCE_DETECT_ENABLE_BIT = 6;
  localparam int ADCC_CFG_BUF_BIT = 4;
  localparam int ADCC_CFG_GAIN_LSB = 0;

  // ==========================================================================
  // Status register bits.
  localparam int ADCC_ST_READY_N_BIT = 7;
  localparam int ADCC_ST_ERR_BIT = 6;
  localparam int ADCC_ST_NO_REFERENCE_FLAG_BIT = 5;

  // ==========================================================================
  // Reset values and the all-ones result forced while the reference is lost.
  localparam logic [23:0] ADCC_MODE_RST = 24'h480000;
  localparam logic [23:0] ADCC_CFG_RST = 24'h000110;
  localparam logic [23:0] ADCC_OFFSET_RST = 24'h800000;
  localparam logic [23:0] ADCC_ALL_ONES = 24'hFFFFFF;

  // Gain codes outside the six supported gains.
  localparam logic [2:0] ADCC_GAIN_RSVD_A = 3'h1;
  localparam logic [2:0] ADCC_GAIN_RSVD_B = 3'h2;

  typedef enum logic [1:0] {ADCC_SER_COMM, ADCC_SER_WRITE, ADCC_SER_READ} adcc_ser_t;

endpackage

// [adcc_host.sv]
// Host-side serial master model that drives register frames into the control block.
`timescale 1ns/1ps
module adcc_host (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  // Three system clocks per serial half period keeps clear of the two-cycle minimum.
  localparam int HALF = 3;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b0;
  end

  // ==========================================================================
  // Frame: command byte, then nbits MSB first; fewer bits than the register holds abort it.
  task automatic frame(input logic [7:0] cmd, input int nbits, input logic [23:0] wdat, output logic [23:0] rdat);
    logic [31:0] sh;
    rdat = 24'h000000;
    sh = {cmd, wdat << (24 - nbits)};
    @(posedge clk_i);
    #1;
    cs_n_o = 1'b0;
    for (int i = 0; i < 8 + nbits; i++) begin
      repeat (HALF) @(posedge clk_i);
      #1;
      sclk_o = 1'b0;
      din_o = sh[31-i];
      repeat (HALF) @(posedge clk_i);
      #1;
      if (i >= 8) begin
        rdat = {rdat[22:0], dout_i};
      end
      sclk_o = 1'b1;
    end
    repeat (HALF) @(posedge clk_i);
    #1;
    cs_n_o = 1'b1;
    // A released data line must not keep showing the last bit.
    din_o = ~din_o;
  endtask
endmodule // adcc_host

// [adcc_ctrl_tb_top.sv]
// Self-checking testbench for the calibration and reference control block.
`timescale 1ns/1ps
module adcc_ctrl_tb_top;
  localparam logic [23:0] FS_INIT = 24'h5A5A50;
  logic clk = 1'b0, rstn = 1'b0, ref_low = 1'b0, ref_high = 1'b0, conv_done = 1'b0, cal_done = 1'b0;
  logic [23:0] conv_data = 24'h000000, cal_coef = 24'h000000, rd, offs, fs;
  logic cs_n, sclk, din, dout, cal_start, mcom, buf_en, rsel, rtwo, no_reference_flag;
  logic [2:0] mode, gain;
  logic [1:0] clk_src;
  logic [3:0] mpos, mneg;
  int mismatches = 0, samples_checked = 0, starts = 0;

  initial forever #50 clk = ~clk;
  always @(posedge clk) if (cal_start === 1'b1) starts <= starts + 1;

  adcc_host i_adcc_host (.clk_i(clk), .dout_i(dout), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  adcc_ctrl #(.FULL_SCALE_FACTORY(FS_INIT)) i_adcc_ctrl (
    .clk_i(clk), .rstn_i(rstn), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .ref_below_low_i(ref_low), .ref_above_high_i(ref_high), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .cal_done_i(cal_done), .cal_coef_i(cal_coef), .dout_o(dout),
    .active_mode_o(mode), .clk_src_o(clk_src), .cal_start_o(cal_start), .mux_pos_o(mpos),
    .mux_neg_o(mneg), .mux_neg_common_o(mcom), .buf_en_o(buf_en), .gain_o(gain),
    .reference_source_choice_o(rsel), .ref_two_pins_ref_o(rtwo), .no_reference_flag_o(no_reference_flag),
    .offset_coef_o(offs), .full_scale_coef_o(fs));

  // ==========================================================================
  // Shared helpers.
  task automatic wrap_up;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] r, input logic [23:0] d);
    i_adcc_host.frame({2'b00, r, 3'b000}, 24, d, rd);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic rdr(input logic [2:0] r, input int n, output logic [23:0] d);
    i_adcc_host.frame({2'b01, r, 3'b000}, n, 24'h000000, d);
  endtask

  task automatic pulse(input logic cal, input logic [23:0] d);
    @(posedge clk);
    #1;
    if (cal) begin
      cal_coef = d;
      cal_done = 1'b1;
    end else begin
      conv_data = d;
      conv_done = 1'b1;
    end
    @(posedge clk);
    #1;
    cal_done = 1'b0;
    conv_done = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset_values;
    rdr(3'h6, 24, rd);
    chk(rd, 24'h800000, "offset reset read");
    chk(offs, 24'h800000, "offset reset port");
    rdr(3'h7, 24, rd);
    chk(rd, FS_INIT, "full-scale reset read");
    rdr(3'h4, 24, rd);
    chk(rd, 24'h000000, "unmapped read");
  endtask

  task automatic t_coef_write;
    wr(3'h6, 24'h123456);
    rdr(3'h6, 24, rd);
    chk(rd, 24'h123456, "offset readback");
    chk(offs, 24'h123456, "offset port");
    wr(3'h7, 24'hABCDEF);
    rdr(3'h7, 24, rd);
    chk(rd, 24'hABCDEF, "full-scale readback");
    i_adcc_host.frame(8'h30, 12, 24'h000FFF, rd);
    repeat (3) @(posedge clk);
    #1;
    chk(offs, 24'h123456, "aborted write kept out");
  endtask

  task automatic t_calibrations;
    int s0;
    logic [23:0] c;
    for (logic [3:0] m = 4'h4; m <= 4'h7; m++) begin
      s0 = starts;
      c = {4'h1, 1'b0, m[2:0], 16'h5A5A};
      wr(3'h1, {m[2:0], 1'b0, 2'h2, 18'h00000});
      chk(24'(starts - s0), 24'h000001, "calibration start pulse");
      chk({22'h000000, clk_src}, 24'h000002, "clock source");
      pulse(1'b1, c);
      chk({21'h000000, mode}, 24'h000002, "idle after calibration");
      chk(m[0] ? fs : offs, c, "calibrated coefficient");
    end
  endtask

  task automatic t_routing;
    wr(3'h2, 24'h153A07);
    chk({mpos, mneg, 15'h0000, mcom}, {8'h3A, 15'h0000, 1'b1}, "routing");
    chk({buf_en, gain, rsel, rtwo}, {1'b0, 3'h7, 1'b1, 1'b1}, "buffer gain reference");
    wr(3'h2, 24'h003A11);
    chk({buf_en, gain, mcom}, {1'b1, 3'h7, 1'b0}, "reserved gain kept out");
  endtask

  task automatic t_reference;
    ref_low = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({23'h000000, no_reference_flag}, 24'h000000, "supervision off");
    wr(3'h2, 24'h000150);
    chk({23'h000000, no_reference_flag}, 24'h000001, "flag set below low");
    wr(3'h6, 24'h654321);
    wr(3'h1, 24'h800000);
    pulse(1'b1, 24'h111111);
    chk(offs, 24'h654321, "blocked calibration");
    rdr(3'h0, 8, rd);
    chk({22'h000000, rd[6:5]}, 24'h000003, "error and flag in status");
    wr(3'h1, 24'h000000);
    pulse(1'b0, 24'h00ABCD);
    rdr(3'h3, 24, rd);
    chk(rd, 24'hFFFFFF, "forced result");
    ref_low = 1'b0;
    ref_high = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({23'h000000, no_reference_flag}, 24'h000000, "flag cleared above high");
    pulse(1'b0, 24'h00ABCD);
    rdr(3'h3, 24, rd);
    chk(rd, 24'h00ABCD, "normal result");
    ref_high = 1'b0;
  endtask

  task automatic t_sync_change;
    ref_low = 1'b1;
    wr(3'h2, 24'h005610);
    chk({23'h000000, no_reference_flag}, 24'h000000, "supervision disabled");
    chk({20'h00000, mpos}, 24'h000000, "no change mid-conversion");
    pulse(1'b0, 24'h000042);
    chk({16'h0000, mpos, mneg}, 24'h000056, "change at conversion end");
    // A single conversion drops to power-down, where coefficient writes land as in any other mode.
    wr(3'h1, 24'h200000);
    pulse(1'b0, 24'h000777);
    chk({21'h000000, mode}, 24'h000003, "power-down after single");
    rdr(3'h3, 24, rd);
    chk(rd, 24'h000777, "single result");
    wr(3'h6, 24'h0F0F0F);
    chk(offs, 24'h0F0F0F, "offset written in power-down");
    ref_low = 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    t_reset_values();
    t_coef_write();
    t_calibrations();
    t_routing();
    t_reference();
    t_sync_change();
    wrap_up();
  end
endmodule // adcc_ctrl_tb_top
